// File: hw/adcrf_map.svh
`ifndef ADCRF_MAP_SVH
`define ADCRF_MAP_SVH

// ---------------------------------------------------------------
// register indices on the local port
// ---------------------------------------------------------------
`define ADCRF_OFF_CTRL0 3'h0
`define ADCRF_OFF_CTRL1 3'h1
`define ADCRF_OFF_RES_HI 3'h2
`define ADCRF_OFF_RES_LO 3'h3
`define ADCRF_OFF_IRQ_STAT 3'h4
`define ADCRF_OFF_IRQ_MASK 3'h5

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define ADCRF_RST_CTRL0 8'h00
`define ADCRF_RST_CTRL1 8'h00
`define ADCRF_RST_IRQ 8'h00
`define ADCRF_IRQ_DONE_BIT 0
`define ADCRF_ZERO6 6'h00

// ---------------------------------------------------------------
// channel codes
// ---------------------------------------------------------------
`define ADCRF_CHAN_AN_MAX 5'h10
`define ADCRF_CHAN_TEMP 5'h1D
`define ADCRF_CHAN_DAC 5'h1E
`define ADCRF_CHAN_FIXREF 5'h1F

// ---------------------------------------------------------------
// conversion clock divisors, in system clocks
// ---------------------------------------------------------------
`define ADCRF_DIV_2 7'h02
`define ADCRF_DIV_8 7'h08
`define ADCRF_DIV_32 7'h20
`define ADCRF_DIV_4 7'h04
`define ADCRF_DIV_16 7'h10
`define ADCRF_DIV_64 7'h40
`define ADCRF_FRC_DIV_DEF 7'h19

// ---------------------------------------------------------------
// result size
// ---------------------------------------------------------------
`define ADCRF_RES_W 10
`define ADCRF_MSB_IDX 4'h9

`endif

// File: hw/adcrf_pkg.sv
package adcrf_pkg;

  typedef enum logic [2:0]
  {
    ADCRF_CK_DIV2,
    ADCRF_CK_DIV8,
    ADCRF_CK_DIV32,
    ADCRF_CK_FRC_A,
    ADCRF_CK_DIV4,
    ADCRF_CK_DIV16,
    ADCRF_CK_DIV64,
    ADCRF_CK_FRC_B
  } adcrf_clk_sel_t;

  typedef struct packed {
    logic unused7;
    logic [4:0] input_channel_field;
    logic conversion_go;
    logic converter_power_on;
  } adcrf_ctrl0_t;

  typedef struct packed {
    logic result_justify_select;
    adcrf_clk_sel_t conversion_clock_field;
    logic unused3;
    logic negative_reference_select;
    logic [1:0] positive_reference_select;
  } adcrf_ctrl1_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcrf_bus_req_t;

  typedef struct packed {
    logic [4:0] analog_input;
    logic analog_valid;
    logic temp_sel;
    logic dac_sel;
    logic fixed_reference_sel;
  } adcrf_chan_sel_t;

  typedef enum logic [1:0]
  {
    ADCRF_IDLE,
    ADCRF_HOLD,
    ADCRF_TRIAL
  } adcrf_state_t;

endpackage : adcrf_pkg

// File: hw/adcrf_top.sv
// Function
// - left justify: bits 1-0 top of low
// - right justify: bits 9-8 low of high
// - right justify: bits 7-0 fill low
// - results untouched by ordinary reset
// - ten-bit code, 1024 steps
// - hold capacitor never discharged between conversions
// - go flag set by software, hardware clears
// - unused six result bits zeroed by each conversion; software writes to the result registers can set them
// - five-bit channel field decode
// - three-bit conversion clock select
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "adcrf_map.svh"

module adcrf_top
#(
  parameter logic [6:0] FRC_DIV = `ADCRF_FRC_DIV_DEF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire adcrf_pkg::adcrf_bus_req_t bus_req,
  output logic [7:0] rdata,
  // interrupt
  output logic irq,
  // analog front end
  input wire logic cmp_in,
  output logic [`ADCRF_RES_W-1:0] trial_code,
  output logic sample_closed,
  output logic power_on,
  output adcrf_pkg::adcrf_chan_sel_t chan_sel,
  output logic negative_reference_select,
  output logic [1:0] positive_reference_select
);
  import adcrf_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  adcrf_ctrl0_t ctrl0_reg, ctrl0_next;
  adcrf_ctrl1_t ctrl1_reg, ctrl1_next;
  logic [7:0] res_hi_reg, res_hi_next;
  logic [7:0] res_lo_reg, res_lo_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;
  adcrf_state_t state_reg, state_next;
  logic [6:0] div_cnt_reg, div_cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [`ADCRF_RES_W-1:0] sar_reg, sar_next;
  logic sample_reg, sample_next;
  adcrf_chan_sel_t sel_reg, sel_next;
  logic cmp_s1_reg, cmp_s2_reg, cmp_s3_reg, cmp_q_reg;
  logic cmp_q_next;
  logic [6:0] divisor;
  logic tick;
  logic done;
  logic [`ADCRF_RES_W-1:0] result;

  // ---------------------------------------------------------------
  // comparator synchroniser
  // ---------------------------------------------------------------
  // the filtered level only moves when the last two stages agree
  always_comb
  begin
    cmp_q_next = cmp_q_reg;
    if (cmp_s2_reg == cmp_s3_reg)
    begin
      cmp_q_next = cmp_s3_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
      cmp_s3_reg <= 1'b0;
      cmp_q_reg <= 1'b0;
    end
    else
    begin
      cmp_s1_reg <= cmp_in;
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      cmp_q_reg <= cmp_q_next;
    end
  end

  // ---------------------------------------------------------------
  // conversion clock divisor
  // ---------------------------------------------------------------
  // the rc source has no clock of its own here: it is a fixed divider
  always_comb
  begin
    unique case (ctrl1_reg.conversion_clock_field)
      ADCRF_CK_DIV2: divisor = `ADCRF_DIV_2;
      ADCRF_CK_DIV8: divisor = `ADCRF_DIV_8;
      ADCRF_CK_DIV32: divisor = `ADCRF_DIV_32;
      ADCRF_CK_DIV4: divisor = `ADCRF_DIV_4;
      ADCRF_CK_DIV16: divisor = `ADCRF_DIV_16;
      ADCRF_CK_DIV64: divisor = `ADCRF_DIV_64;
      ADCRF_CK_FRC_A: divisor = FRC_DIV;
      ADCRF_CK_FRC_B: divisor = FRC_DIV;
    endcase
  end

  // ---------------------------------------------------------------
  // registers, conversion engine, interrupt
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    res_hi_next = res_hi_reg;
    res_lo_next = res_lo_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    rdata_next = 8'h00;
    state_next = state_reg;
    div_cnt_next = div_cnt_reg;
    bit_next = bit_reg;
    sar_next = sar_reg;
    tick = 1'b0;
    done = 1'b0;
    result = sar_reg;

    // software writes
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        `ADCRF_OFF_CTRL0:
        begin
          ctrl0_next = adcrf_ctrl0_t'(bus_req.wdata);
          ctrl0_next.unused7 = 1'b0;
          // a start is only taken while the converter is powered
          if (!ctrl0_next.converter_power_on)
          begin
            ctrl0_next.conversion_go = 1'b0;
          end
        end
        `ADCRF_OFF_CTRL1:
        begin
          ctrl1_next = adcrf_ctrl1_t'(bus_req.wdata);
          ctrl1_next.unused3 = 1'b0;
        end
        `ADCRF_OFF_RES_HI: res_hi_next = bus_req.wdata;
        `ADCRF_OFF_RES_LO: res_lo_next = bus_req.wdata;
        `ADCRF_OFF_IRQ_MASK: mask_next = bus_req.wdata & 8'h01;
        default:
        begin
        end
      endcase
    end

    // reads, answered one cycle later; status clears on read
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `ADCRF_OFF_CTRL0: rdata_next = ctrl0_reg;
        `ADCRF_OFF_CTRL1: rdata_next = ctrl1_reg;
        `ADCRF_OFF_RES_HI: rdata_next = res_hi_reg;
        `ADCRF_OFF_RES_LO: rdata_next = res_lo_reg;
        `ADCRF_OFF_IRQ_STAT:
        begin
          rdata_next = stat_reg;
          stat_next = 8'h00;
        end
        `ADCRF_OFF_IRQ_MASK: rdata_next = mask_reg;
        default: rdata_next = 8'h00;
      endcase
    end

    // conversion clock enable
    if (state_reg == ADCRF_IDLE)
    begin
      div_cnt_next = 7'h00;
    end
    else if (div_cnt_reg == divisor - 7'h01)
    begin
      div_cnt_next = 7'h00;
      tick = 1'b1;
    end
    else
    begin
      div_cnt_next = div_cnt_reg + 7'h01;
    end

    // successive approximation, one bit per conversion clock
    unique case (state_reg)
      ADCRF_IDLE:
      begin
        if (ctrl0_reg.conversion_go && ctrl0_reg.converter_power_on)
        begin
          state_next = ADCRF_HOLD;
          sar_next = '0;
        end
      end
      ADCRF_HOLD:
      begin
        if (tick)
        begin
          state_next = ADCRF_TRIAL;
          bit_next = `ADCRF_MSB_IDX;
          sar_next = '0;
          sar_next[`ADCRF_MSB_IDX] = 1'b1;
        end
      end
      ADCRF_TRIAL:
      begin
        if (tick)
        begin
          // comparator high means the input is at or above the trial
          if (!cmp_q_reg)
          begin
            sar_next[bit_reg] = 1'b0;
          end
          if (bit_reg == 4'h0)
          begin
            done = 1'b1;
            state_next = ADCRF_IDLE;
          end
          else
          begin
            bit_next = bit_reg - 4'h1;
            sar_next[bit_reg - 4'h1] = 1'b1;
          end
        end
      end
    endcase

    // software clearing go or power aborts without a result
    if (state_reg != ADCRF_IDLE)
    begin
      if (!ctrl0_reg.conversion_go || !ctrl0_reg.converter_power_on)
      begin
        state_next = ADCRF_IDLE;
        done = 1'b0;
      end
    end

    if (done)
    begin
      result = sar_next;
      ctrl0_next.conversion_go = 1'b0;
      if (ctrl1_reg.result_justify_select)
      begin
        res_hi_next = {`ADCRF_ZERO6, result[9:8]};
        res_lo_next = result[7:0];
      end
      else
      begin
        res_hi_next = result[9:2];
        res_lo_next = {result[1:0], `ADCRF_ZERO6};
      end
      // set wins over a clearing read in the same cycle
      stat_next[`ADCRF_IRQ_DONE_BIT] = 1'b1;
    end

    irq_next = |(stat_next & mask_next);
  end

  // ---------------------------------------------------------------
  // analog side controls
  // ---------------------------------------------------------------
  always_comb
  begin
    sel_next = '0;
    // hold capacitor floats during a conversion or while unpowered and is never
    // discharged, so its charge carries into the next acquisition
    sample_next = ctrl0_next.converter_power_on && (state_next == ADCRF_IDLE);
    if (ctrl0_next.input_channel_field <= `ADCRF_CHAN_AN_MAX)
    begin
      sel_next.analog_input = ctrl0_next.input_channel_field;
      sel_next.analog_valid = 1'b1;
    end
    else
    begin
      sel_next.temp_sel = (ctrl0_next.input_channel_field == `ADCRF_CHAN_TEMP);
      sel_next.dac_sel = (ctrl0_next.input_channel_field == `ADCRF_CHAN_DAC);
      sel_next.fixed_reference_sel =
        (ctrl0_next.input_channel_field == `ADCRF_CHAN_FIXREF);
    end
  end

  // ---------------------------------------------------------------
  // registering
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl0_reg <= adcrf_ctrl0_t'(`ADCRF_RST_CTRL0);
      ctrl1_reg <= adcrf_ctrl1_t'(`ADCRF_RST_CTRL1);
      stat_reg <= `ADCRF_RST_IRQ;
      mask_reg <= `ADCRF_RST_IRQ;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      state_reg <= ADCRF_IDLE;
      div_cnt_reg <= 7'h00;
      bit_reg <= 4'h0;
      sample_reg <= 1'b0;
      sel_reg <= '0;
    end
    else
    begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      state_reg <= state_next;
      div_cnt_reg <= div_cnt_next;
      bit_reg <= bit_next;
      sample_reg <= sample_next;
      sel_reg <= sel_next;
    end
  end

  // results and the approximation word carry no reset: only a power
  // loss leaves them unknown, every other reset keeps them
  always_ff @(posedge clk)
  begin
    res_hi_reg <= res_hi_next;
    res_lo_reg <= res_lo_next;
    sar_reg <= sar_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign trial_code = sar_reg;
  assign sample_closed = sample_reg;
  assign power_on = ctrl0_reg.converter_power_on;
  assign chan_sel = sel_reg;
  assign negative_reference_select = ctrl1_reg.negative_reference_select;
  assign positive_reference_select = ctrl1_reg.positive_reference_select;

endmodule : adcrf_top

`default_nettype wire

// File: tb/adcrf_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module adcrf_chk
#(
  parameter logic [6:0] FRC_DIV = 7'h19
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire adcrf_pkg::adcrf_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic irq,
  // analog side
  input wire logic cmp_in,
  input wire logic [9:0] trial_code,
  input wire logic sample_closed,
  input wire logic power_on,
  input wire adcrf_pkg::adcrf_chan_sel_t chan_sel,
  input wire logic negative_reference_select,
  input wire logic [1:0] positive_reference_select
);
  import adcrf_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // switch opens while powered: a conversion has begun
  sequence conv_start;
    power_on ##1 ($fell(sample_closed) && power_on);
  endsequence
  a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data not zero when idle");
  a_ctrl0_bit7: assert property (bus_req.rd && bus_req.addr == 3'h0 |=> !rdata[7])
    else $error("control 0 bit 7 not zero");
  a_ctrl1_bit3: assert property (bus_req.rd && bus_req.addr == 3'h1 |=> !rdata[3])
    else $error("control 1 bit 3 not zero");
  a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > 3'h5 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_chan_fixref: assert property (bus_req.wr && bus_req.addr == 3'h0 &&
    bus_req.wdata[6:2] == 5'h1F |-> ##[1:2] chan_sel == 9'h001)
    else $error("fixed reference channel not decoded");
  a_refs_follow: assert property (bus_req.wr && bus_req.addr == 3'h1 &&
    bus_req.wdata[2:0] == 3'h7 |-> ##[1:2] negative_reference_select &&
    positive_reference_select == 2'h3)
    else $error("reference selects not loaded");
  a_first_trial: assert property (conv_start |-> ##[1:80] trial_code == 10'h200)
    else $error("first trial word not midscale");
  a_irq_stat: assert property (bus_req.rd && bus_req.addr == 3'h4 && irq &&
    !$past(bus_req.rd) |=> rdata[0])
    else $error("interrupt without done flag");
  a_irq_masked: assert property (bus_req.wr && bus_req.addr == 3'h5 &&
    !bus_req.wdata[0] |=> ##1 !irq)
    else $error("interrupt while masked");
endmodule : adcrf_chk
bind adcrf_top adcrf_chk #(.FRC_DIV(FRC_DIV)) u_chk (.clk(clk), .nrst(nrst),
  .bus_req(bus_req), .rdata(rdata), .irq(irq), .cmp_in(cmp_in), .trial_code(trial_code),
  .sample_closed(sample_closed), .power_on(power_on), .chan_sel(chan_sel),
  .negative_reference_select(negative_reference_select),
  .positive_reference_select(positive_reference_select));
`default_nettype wire

// File: tb/adcrf_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module adcrf_top_test;
  import adcrf_pkg::*;
  logic clk = 1'b0;
  logic nrst;
  adcrf_bus_req_t bus_req;
  logic [7:0] rdata, d, h, l;
  logic irq, cmp_in, sample_closed, power_on, nref;
  logic [9:0] trial_code, tgt;
  logic [1:0] pref;
  adcrf_chan_sel_t chan_sel;
  int fail_count = 0;
  int comparisons = 0;
  // rc clock shortened from 25 to 8 system clocks; the comparator filter keeps up at either length
  int dv[8] = '{2, 8, 32, 8, 4, 16, 64, 8};
  logic [9:0] tv[8] = '{10'h155, 10'h3FF, 10'h000, 10'h2A6, 10'h200, 10'h1FF, 10'h0C3,
    10'h301};
  logic [4:0] cv[6] = '{5'h00, 5'h10, 5'h11, 5'h1D, 5'h1E, 5'h1F};
  // ways to stop a running conversion: drop the go bit, or drop power too
  logic [7:0] sv[2] = '{8'h01, 8'h00};
  adcrf_top #(.FRC_DIV(7'h08)) uut (.clk(clk), .nrst(nrst), .bus_req(bus_req),
    .rdata(rdata), .irq(irq), .cmp_in(cmp_in), .trial_code(trial_code),
    .sample_closed(sample_closed), .power_on(power_on), .chan_sel(chan_sel),
    .negative_reference_select(nref), .positive_reference_select(pref));
  always #10 clk = ~clk;
  // ideal comparator: input at or above the trial word
  always @(posedge clk)
    cmp_in <= ((trial_code <= tgt) === 1'b1);
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] v);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] v);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask : rd
  task conv(input logic [2:0] c, input int lo);
    int n;
    n = 0;
    tgt <= tv[c];
    wr(3'h1, {c[0], c, 4'h0});
    // channel and power first, start only once the input has settled
    wr(3'h0, 8'h01);
    repeat (10) @(posedge clk);
    chk("switch closed", 1, sample_closed);
    chk("power", 1, power_on);
    wr(3'h0, 8'h03);
    d = 8'h02;
    while (d[1] !== 1'b0 && n < 3000)
    begin
      rd(3'h0, d);
      n += 2;
    end
    chk("duration", 1, n >= lo && n <= lo + 6);
  endtask : conv
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run;
  end
  initial
  begin
    nrst <= 1'b0;
    bus_req <= '0;
    tgt <= 10'h000;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 2 || i == 3)
        continue;
      rd(3'(i), d);
      chk("reset value", 8'h00, d);
    end
    wr(3'h1, 8'hFF);
    rd(3'h1, d);
    chk("control 1", 8'hF7, d);
    chk("references", 3'h7, {nref, pref});
    wr(3'h7, 8'hFF);
    rd(3'h7, d);
    chk("unmapped", 8'h00, d);
    wr(3'h5, 8'hFF);
    rd(3'h5, d);
    chk("mask", 8'h01, d);
    foreach (cv[i])
    begin
      wr(3'h0, {1'b1, cv[i], 2'b00});
      rd(3'h0, d);
      chk("control 0", {1'b0, cv[i], 2'b00}, d);
      chk("channel", {cv[i] <= 5'h10 ? cv[i] : 5'h00, cv[i] <= 5'h10, cv[i] == 5'h1D,
        cv[i] == 5'h1E, cv[i] == 5'h1F}, chan_sel);
    end
    for (int c = 0; c < 8; c++)
    begin
      conv(3'(c), 11 * dv[c] - 2);
      chk("irq raised", 1, irq);
      if (dv[c] >= 8)
      begin
        rd(3'h2, h);
        rd(3'h3, l);
        chk("result", c[0] ? {6'h00, tv[c]} : {tv[c], 6'h00}, {h, l});
      end
      rd(3'h4, d);
      chk("done flag", 8'h01, d);
      repeat (3) @(posedge clk);
      chk("irq cleared", 0, irq);
      rd(3'h4, d);
      chk("flag cleared", 8'h00, d);
    end
    wr(3'h5, 8'h00);
    conv(3'h1, 86);
    chk("irq masked", 0, irq);
    rd(3'h4, d);
    chk("masked flag", 8'h01, d);
    rd(3'h2, h);
    rd(3'h3, l);
    foreach (sv[i])
    begin
      wr(3'h0, 8'h03);
      repeat (20) @(posedge clk);
      chk("switch open", 0, sample_closed);
      wr(3'h0, sv[i]);
      repeat (150) @(posedge clk);
      rd(3'h4, d);
      chk("aborted flag", 8'h00, d);
      rd(3'h0, d);
      chk("aborted go", sv[i], d);
    end
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(3'h2, d);
    chk("high kept", h, d);
    rd(3'h3, d);
    chk("low kept", l, d);
    complete_run;
  end
endmodule : adcrf_top_test
`default_nettype wire
